/* File: hw/timer_split_pkg.sv */
// Shared constants, register indices and field layouts of the split reload timer.
// Assumes a single system clock; register indices are multiplied by four on the bus.
`default_nettype none

package timer_split_pkg;

   // ----------------------------------------------------------------
   // Widths and timing
   // ----------------------------------------------------------------
   localparam int CNT_W   = 8;
   localparam int ADDR_W  = 12;
   localparam int DATA_W  = 32;
   localparam int DIV_SYS = 12;
   localparam int DIV_EXT = 8;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [9:0] IDX_CTRL     = 10'h090;
   localparam logic [9:0] IDX_CLKCTL   = 10'h091;
   localparam logic [9:0] IDX_RLD_LO   = 10'h092;
   localparam logic [9:0] IDX_RLD_HI   = 10'h093;
   localparam logic [9:0] IDX_CNT_LO   = 10'h094;
   localparam logic [9:0] IDX_CNT_HI   = 10'h095;
   localparam logic [9:0] IDX_IRQ_STAT = 10'h096;
   localparam logic [9:0] IDX_IRQ_CLR  = 10'h097;
   localparam logic [9:0] IDX_IRQ_EN   = 10'h098;

   // ----------------------------------------------------------------
   // Values
   // ----------------------------------------------------------------
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [7:0]  CNT_MAX  = 8'hff;
   localparam logic [23:0] PAD_HI   = 24'h000000;
   localparam logic [5:0]  PAD_IRQ  = 6'h00;

   // ----------------------------------------------------------------
   // Field layouts
   // ----------------------------------------------------------------
   typedef struct packed {
      logic high_overflow_flag;
      logic low_overflow_flag;
      logic low_overflow_irq_enable;
      logic rsv4;
      logic split_mode_bit;
      logic high_half_run;
      logic rsv1;
      logic external_clock_select;
   } ctrl_t;

   typedef struct packed {
      logic       high_half_clock_mode;
      logic       low_half_clock_mode;
      logic [5:0] rsv;
   } clkctl_t;

   typedef struct packed {
      logic low;
      logic high;
   } ovf_t;

   // Count enable of one half from its clock mode and the shared source select.
   function automatic logic pick_step(input logic sys_mode, input logic ext_sel,
                                      input logic tick_sys, input logic tick_ext);
      return sys_mode ? 1'b1 : (ext_sel ? tick_ext : tick_sys);
   endfunction : pick_step

endpackage : timer_split_pkg

`default_nettype wire

/* File: hw/tick_source.sv */
// Prescaler giving one-cycle ticks at system clock / DIV_SYS and external clock / DIV_EXT.
// Assumes the external clock input is synchronous to the system clock and slower than it.
`default_nettype none

module tick_source
   import timer_split_pkg::*;
#(
   parameter int P_DIV_SYS = DIV_SYS,
   parameter int P_DIV_EXT = DIV_EXT
)
(
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst_b,
   input  wire logic i_ce,
   // External oscillator clock
   input  wire logic i_ext_clk,
   // Ticks
   output logic      o_tick_sys,
   output logic      o_tick_ext
);

   localparam int SW = $clog2(P_DIV_SYS);
   localparam int EW = $clog2(P_DIV_EXT);
   localparam logic [SW-1:0] SYS_LAST = SW'(P_DIV_SYS - 1);
   localparam logic [EW-1:0] EXT_LAST = EW'(P_DIV_EXT - 1);

   logic [SW-1:0] sys_cnt_r;
   logic [EW-1:0] ext_cnt_r;
   logic          ext_d_r;
   logic          ext_rise;

   assign ext_rise = i_ext_clk & ~ext_d_r;

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         sys_cnt_r  <= '0;
         o_tick_sys <= 1'b0;
      end
      else if (i_ce)
      begin
         sys_cnt_r  <= (sys_cnt_r == SYS_LAST) ? '0 : sys_cnt_r + 1'b1;
         o_tick_sys <= (sys_cnt_r == SYS_LAST);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         ext_d_r    <= 1'b0;
         ext_cnt_r  <= '0;
         o_tick_ext <= 1'b0;
      end
      else if (i_ce)
      begin
         ext_d_r    <= i_ext_clk;
         o_tick_ext <= ext_rise && (ext_cnt_r == EXT_LAST);
         if (ext_rise)
         begin
            ext_cnt_r <= (ext_cnt_r == EXT_LAST) ? '0 : ext_cnt_r + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // Enabled cycles since the last system tick, so the spacing is checked without a long repetition.
   localparam int GAP_W = $clog2(P_DIV_SYS + 1);

   logic [GAP_W-1:0] gap_r;

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         gap_r <= '0;
      end
      else if (i_ce)
      begin
         gap_r <= o_tick_sys ? GAP_W'(1) : gap_r + GAP_W'(1);
      end
   end

   property p_div12;
      @(posedge i_clk) disable iff (!i_rst_b)
      i_ce && o_tick_sys |-> gap_r == GAP_W'(P_DIV_SYS);
   endproperty
   a_div12: assert property (p_div12)
      else $error("Divide-by-twelve tick spacing wrong.");

endmodule : tick_source

`default_nettype wire

/* File: hw/reload_half.sv */
// One 8-bit half of the timer: counts on a step, reloads or wraps at its top value.
// Gives a software write priority over a step or an overflow in the same cycle.
`default_nettype none

module reload_half
   import timer_split_pkg::*;
#(
   parameter int W = CNT_W
)
(
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst_b,
   input  wire logic         i_ce,
   // Counting
   input  wire logic         i_step,
   input  wire logic         i_wrap_to_reload,
   input  wire logic [W-1:0] i_reload,
   // Software write
   input  wire logic         i_wr,
   input  wire logic [W-1:0] i_wdata,
   // State
   output logic [W-1:0]      o_count,
   output logic              o_ovf
);

   assign o_ovf = i_step && (o_count == {W{1'b1}});

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_count <= '0;
      end
      else if (i_ce)
      begin
         if (i_wr)
         begin
            o_count <= i_wdata;
         end
         else if (o_ovf)
         begin
            o_count <= i_wrap_to_reload ? i_reload : '0;
         end
         else if (i_step)
         begin
            o_count <= o_count + 1'b1;
         end
      end
   end

endmodule : reload_half

`default_nettype wire

/* File: hw/split_timer.sv */
// Split-mode reload timer with APB register access and one level interrupt.
// Assumes an APB master on the system clock and an external clock input synchronous to it.
//
// The APB register port is this design's own decision.
`default_nettype none

module split_timer
   import timer_split_pkg::*;
(
   // Clock, reset and clock enable
   input  wire logic              I_REF_CLK,
   input  wire logic              I_RST_B,
   input  wire logic              I_CE,
   // External oscillator clock
   input  wire logic              I_EXT_CLK,
   // APB slave
   input  wire logic              I_PSEL,
   input  wire logic              I_PENABLE,
   input  wire logic              I_PWRITE,
   input  wire logic [ADDR_W-1:0] I_PADDR,
   input  wire logic [DATA_W-1:0] I_PWDATA,
   input  wire logic [3:0]        I_PSTRB,
   output logic [DATA_W-1:0]      O_PRDATA,
   output logic                   O_PREADY,
   output logic                   O_PSLVERR,
   // Interrupt
   output logic                   O_IRQ
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   ctrl_t            ctrl_r;
   clkctl_t          clkctl_r;
   ovf_t             irq_en_r;
   logic [CNT_W-1:0] rld_lo_r;
   logic [CNT_W-1:0] rld_hi_r;
   logic [CNT_W-1:0] cnt_lo;
   logic [CNT_W-1:0] cnt_hi;
   logic             ovf_lo;
   logic             ovf_hi;
   logic             tick_sys;
   logic             tick_ext;
   logic             src_lo;
   logic             src_hi;
   logic             step_lo;
   logic             step_hi;
   logic             wrap_lo;
   logic [9:0]       idx;
   logic             setup;
   logic             wr_en;
   logic             hit;
   logic [7:0]       rd_byte;
   logic [7:0]       wbyte;
   logic             wr_ctrl;
   logic             wr_clr;
   logic             hf_nxt;
   logic             lf_nxt;
   logic             irq_nxt;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   assign idx   = I_PADDR[ADDR_W-1:2];
   assign wbyte = I_PWDATA[7:0];
   assign setup = I_PSEL & ~I_PENABLE;
   assign wr_en = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE & I_PSTRB[0] & hit & I_CE;
   assign wr_ctrl = wr_en && (idx == IDX_CTRL);
   assign wr_clr  = wr_en && (idx == IDX_IRQ_CLR);

   always_comb
   begin
      hit     = (I_PADDR[1:0] == 2'b00);
      rd_byte = RST_BYTE;
      unique case (idx)
         IDX_CTRL:     rd_byte = ctrl_r;
         IDX_CLKCTL:   rd_byte = clkctl_r;
         IDX_RLD_LO:   rd_byte = rld_lo_r;
         IDX_RLD_HI:   rd_byte = rld_hi_r;
         IDX_CNT_LO:   rd_byte = cnt_lo;
         IDX_CNT_HI:   rd_byte = cnt_hi;
         IDX_IRQ_STAT: rd_byte = {PAD_IRQ, ctrl_r.low_overflow_flag, ctrl_r.high_overflow_flag};
         IDX_IRQ_CLR:  rd_byte = RST_BYTE;
         IDX_IRQ_EN:   rd_byte = {PAD_IRQ, irq_en_r};
         default:      hit     = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Bus answer: one wait-free access phase, error on unmapped address
   // ----------------------------------------------------------------
   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         O_PREADY  <= 1'b0;
         O_PSLVERR <= 1'b0;
         O_PRDATA  <= '0;
      end
      else if (I_CE)
      begin
         O_PREADY  <= setup;
         O_PSLVERR <= setup & ~hit;
         if (setup && !I_PWRITE)
         begin
            O_PRDATA <= {PAD_HI, rd_byte};
         end
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         rld_lo_r <= RST_BYTE;
         rld_hi_r <= RST_BYTE;
      end
      else if (I_CE)
      begin
         if (wr_en && idx == IDX_RLD_LO)
         begin
            rld_lo_r <= wbyte;
         end
         if (wr_en && idx == IDX_RLD_HI)
         begin
            rld_hi_r <= wbyte;
         end
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         clkctl_r <= RST_BYTE;
         irq_en_r <= '0;
      end
      else if (I_CE)
      begin
         if (wr_en && idx == IDX_CLKCTL)
         begin
            clkctl_r <= wbyte;
         end
         if (wr_en && idx == IDX_IRQ_EN)
         begin
            irq_en_r <= wbyte[1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Control register and overflow flags
   // ----------------------------------------------------------------
   // A hardware overflow beats a software clear in the same cycle.
   always_comb
   begin
      hf_nxt = ctrl_r.high_overflow_flag;
      lf_nxt = ctrl_r.low_overflow_flag;
      if (wr_ctrl)
      begin
         hf_nxt = wbyte[7];
         lf_nxt = wbyte[6];
      end
      if (wr_clr && wbyte[0])
      begin
         hf_nxt = 1'b0;
      end
      if (wr_clr && wbyte[1])
      begin
         lf_nxt = 1'b0;
      end
      if (ovf_hi)
      begin
         hf_nxt = 1'b1;
      end
      if (ovf_lo)
      begin
         lf_nxt = 1'b1;
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         ctrl_r <= RST_BYTE;
      end
      else if (I_CE)
      begin
         if (wr_ctrl)
         begin
            ctrl_r <= wbyte;
         end
         ctrl_r.high_overflow_flag <= hf_nxt;
         ctrl_r.low_overflow_flag  <= lf_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Count sources and steps
   // ----------------------------------------------------------------
   tick_source u_ticks (
      .i_clk      (I_REF_CLK),
      .i_rst_b    (I_RST_B),
      .i_ce       (I_CE),
      .i_ext_clk  (I_EXT_CLK),
      .o_tick_sys (tick_sys),
      .o_tick_ext (tick_ext)
   );

   assign src_lo = pick_step(clkctl_r.low_half_clock_mode, ctrl_r.external_clock_select,
                             tick_sys, tick_ext);
   assign src_hi = pick_step(clkctl_r.high_half_clock_mode, ctrl_r.external_clock_select,
                             tick_sys, tick_ext);

   // In 16-bit operation the high byte steps on the low byte's carry.
   assign step_lo = ctrl_r.split_mode_bit ? src_lo : (src_lo & ctrl_r.high_half_run);
   assign step_hi = ctrl_r.split_mode_bit ? (src_hi & ctrl_r.high_half_run) : ovf_lo;
   assign wrap_lo = ctrl_r.split_mode_bit | (cnt_hi == CNT_MAX);

   // ----------------------------------------------------------------
   // Counter halves
   // ----------------------------------------------------------------
   reload_half u_low (
      .i_clk            (I_REF_CLK),
      .i_rst_b          (I_RST_B),
      .i_ce             (I_CE),
      .i_step           (step_lo),
      .i_wrap_to_reload (wrap_lo),
      .i_reload         (rld_lo_r),
      .i_wr             (wr_en && idx == IDX_CNT_LO),
      .i_wdata          (wbyte),
      .o_count          (cnt_lo),
      .o_ovf            (ovf_lo)
   );

   reload_half u_high (
      .i_clk            (I_REF_CLK),
      .i_rst_b          (I_RST_B),
      .i_ce             (I_CE),
      .i_step           (step_hi),
      .i_wrap_to_reload (1'b1),
      .i_reload         (rld_hi_r),
      .i_wr             (wr_en && idx == IDX_CNT_HI),
      .i_wdata          (wbyte),
      .o_count          (cnt_hi),
      .o_ovf            (ovf_hi)
   );

   // ----------------------------------------------------------------
   // Interrupt
   // ----------------------------------------------------------------
   assign irq_nxt = irq_en_r.high & (ctrl_r.high_overflow_flag |
                    (irq_en_r.low & ctrl_r.low_overflow_irq_enable & ctrl_r.low_overflow_flag));

   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         O_IRQ <= 1'b0;
      end
      else if (I_CE)
      begin
         O_IRQ <= irq_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge I_REF_CLK);
   endclocking
   default disable iff (!I_RST_B);

   property p_split_lo_count;
      I_CE && ctrl_r.split_mode_bit && step_lo && cnt_lo != CNT_MAX && !(wr_en && idx == IDX_CNT_LO)
      |=> cnt_lo == $past(cnt_lo) + 8'h01;
   endproperty
   a_split_lo_count: assert property (p_split_lo_count)
      else $error("Low half did not advance by one.");

   property p_lo_reload;
      I_CE && ctrl_r.split_mode_bit && ovf_lo && !(wr_en && idx == IDX_CNT_LO)
      |=> cnt_lo == $past(rld_lo_r);
   endproperty
   a_lo_reload: assert property (p_lo_reload)
      else $error("Low half did not reload from its reload register.");

   property p_hi_reload;
      I_CE && ctrl_r.split_mode_bit && ovf_hi && !(wr_en && idx == IDX_CNT_HI)
      |=> cnt_hi == $past(rld_hi_r);
   endproperty
   a_hi_reload: assert property (p_hi_reload)
      else $error("High half did not reload on overflow.");

   property p_hi_stopped;
      I_CE && ctrl_r.split_mode_bit && !ctrl_r.high_half_run && !(wr_en && idx == IDX_CNT_HI)
      |=> $stable(cnt_hi);
   endproperty
   a_hi_stopped: assert property (p_hi_stopped)
      else $error("High half moved while stopped.");

   property p_lo_free;
      ctrl_r.split_mode_bit && src_lo |-> step_lo;
   endproperty
   a_lo_free: assert property (p_lo_free)
      else $error("Low half gated in split mode.");

   property p_sys_mode;
      I_CE && ctrl_r.split_mode_bit && clkctl_r.low_half_clock_mode && cnt_lo != CNT_MAX
      && !(wr_en && idx == IDX_CNT_LO) ##1 I_CE |-> cnt_lo == $past(cnt_lo) + 8'h01;
   endproperty
   a_sys_mode: assert property (p_sys_mode)
      else $error("System clock mode did not count every cycle.");

   property p_flag_set;
      I_CE && ovf_hi |=> ctrl_r.high_overflow_flag;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("High overflow flag not set.");

   property p_flag_held;
      I_CE && ctrl_r.low_overflow_flag && !wr_ctrl && !wr_clr |=> ctrl_r.low_overflow_flag;
   endproperty
   a_flag_held: assert property (p_flag_held)
      else $error("Low overflow flag cleared by hardware.");

   property p_irq_high;
      I_CE && irq_en_r.high && ctrl_r.high_overflow_flag |=> O_IRQ;
   endproperty
   a_irq_high: assert property (p_irq_high)
      else $error("Interrupt missing on high overflow.");

   property p_irq_low;
      I_CE && irq_en_r.high && irq_en_r.low && ctrl_r.low_overflow_irq_enable
      && ctrl_r.low_overflow_flag |=> O_IRQ;
   endproperty
   a_irq_low: assert property (p_irq_low)
      else $error("Interrupt missing on low overflow.");

   property p_rd_lo;
      I_CE && setup && !I_PWRITE && idx == IDX_CNT_LO |=> O_PRDATA[7:0] == $past(cnt_lo);
   endproperty
   a_rd_lo: assert property (p_rd_lo)
      else $error("Low count read back wrong.");

   c_lo_ovf: cover property (ctrl_r.split_mode_bit && ovf_lo);
   c_hi_ovf: cover property (ctrl_r.split_mode_bit && ovf_hi);
   c_irq:    cover property ($rose(O_IRQ));
   c_16bit:  cover property (!ctrl_r.split_mode_bit && ovf_hi);

endmodule : split_timer

`default_nettype wire

/* File: test/split_timer_tb.sv */
// Self-checking bench for the split reload timer: APB register tests, counting, overflow and interrupt.
// Assumes the design files and timer_split_pkg are compiled first; CE is held high throughout.
`default_nettype none

module split_timer_tb
   import timer_split_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic              clk;
   logic              rst_b;
   logic              ext_clk = 1'b0;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata;
   logic [3:0]        pstrb;
   logic [DATA_W-1:0] prdata;
   logic              pready;
   logic              pslverr;
   logic              irq;
   logic [DATA_W-1:0] rv;
   logic              err;
   int                fails;
   int                n_checks;
   int                cycles;

   split_timer u_dut (
      .I_REF_CLK (clk),
      .I_RST_B   (rst_b),
      .I_CE      (1'b1),
      .I_EXT_CLK (ext_clk),
      .I_PSEL    (psel),
      .I_PENABLE (penable),
      .I_PWRITE  (pwrite),
      .I_PADDR   (paddr),
      .I_PWDATA  (pwdata),
      .I_PSTRB   (pstrb),
      .O_PRDATA  (prdata),
      .O_PREADY  (pready),
      .O_PSLVERR (pslverr),
      .O_IRQ     (irq)
   );

   // ----------------------------------------------------------------
   // Clocks and timeout
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // The external clock rises every second cycle, so eight rises take sixteen cycles.
   always @(posedge clk)
   begin
      ext_clk <= ~ext_clk;
   end

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         summarize();
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= {24'h000000, wd};
      @(posedge clk);
      penable <= 1'b1;
      // Waits for the answer; only the bench timeout ends a hang.
      do
      begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rv  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
   endtask : wr

   task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 8'h00);
      check(rv, exp);
   endtask : rd

   // Measures the low count advance across a window of gap cycles between two read setups.
   task automatic delta(input logic [7:0] ck, input logic [7:0] ct, input int gap, input logic [7:0] exp);
      logic [7:0] v0;
      wr(IDX_CLKCTL, ck);
      wr(IDX_CTRL, ct);
      wr(IDX_CNT_LO, 8'h00);
      apb(1'b0, IDX_CNT_LO, 8'h00);
      v0 = rv[7:0];
      repeat (gap - 3) @(posedge clk);
      apb(1'b0, IDX_CNT_LO, 8'h00);
      check({24'h000000, 8'(rv[7:0] - v0)}, {24'h000000, exp});
   endtask : delta

   task automatic summarize();
      $display("checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      rst_b   = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h00000000;
      pstrb   = 4'h1;
      fails   = 0;
      n_checks = 0;
      cycles  = 0;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;

      rd(IDX_RLD_LO, 32'h00000000);
      rd(IDX_RLD_HI, 32'h00000000);
      rd(IDX_CNT_LO, 32'h00000000);
      rd(IDX_IRQ_EN, 32'h00000000);
      check(irq, 1'b0);
      apb(1'b0, 10'h0a0, 8'h00);
      check(err, 1'b1);
      check(rv, 32'h00000000);
      $display("test reset and map done");

      wr(IDX_CTRL, 8'h00);
      wr(IDX_CNT_LO, 8'h3c);
      rd(IDX_CNT_LO, 32'h0000003c);
      pstrb <= 4'h0;
      wr(IDX_RLD_LO, 8'ha5);
      pstrb <= 4'h1;
      rd(IDX_RLD_LO, 32'h00000000);
      $display("test count access done");

      delta(8'hc0, 8'h08, 30, 8'd30);
      delta(8'h00, 8'h08, 120, 8'd10);
      delta(8'h00, 8'h09, 128, 8'd8);
      delta(8'h40, 8'h09, 30, 8'd30);
      $display("test sources done");

      wr(IDX_CLKCTL, 8'hc0);
      wr(IDX_RLD_LO, 8'hf0);
      wr(IDX_CTRL, 8'h08);
      wr(IDX_CNT_HI, 8'h55);
      wr(IDX_CNT_LO, 8'hf8);
      repeat (20) @(posedge clk);
      apb(1'b0, IDX_CNT_LO, 8'h00);
      check(rv[7:0] >= 8'hf0, 1'b1);
      rd(IDX_CNT_HI, 32'h00000055);
      apb(1'b0, IDX_IRQ_STAT, 8'h00);
      check(rv & 32'h2, 32'h2);
      wr(IDX_RLD_HI, 8'h80);
      wr(IDX_CTRL, 8'h0c);
      wr(IDX_CNT_HI, 8'hfc);
      repeat (20) @(posedge clk);
      apb(1'b0, IDX_CNT_HI, 8'h00);
      check(rv[7:0] >= 8'h80, 1'b1);
      apb(1'b0, IDX_IRQ_STAT, 8'h00);
      check(rv & 32'h1, 32'h1);
      $display("test overflow done");

      wr(IDX_CTRL, 8'h08);
      wr(IDX_IRQ_CLR, 8'h03);
      rd(IDX_IRQ_CLR, 32'h00000000);
      wr(IDX_IRQ_EN, 8'h01);
      repeat (40) @(posedge clk);
      check(irq, 1'b0);
      wr(IDX_CTRL, 8'h28);
      wr(IDX_IRQ_EN, 8'h03);
      repeat (20) @(posedge clk);
      check(irq, 1'b1);
      wr(IDX_IRQ_EN, 8'h01);
      repeat (2) @(posedge clk);
      check(irq, 1'b0);
      wr(IDX_CTRL, 8'h0c);
      wr(IDX_CNT_HI, 8'hfe);
      repeat (10) @(posedge clk);
      check(irq, 1'b1);
      wr(IDX_CTRL, 8'h88);
      repeat (300) @(posedge clk);
      apb(1'b0, IDX_IRQ_STAT, 8'h00);
      check(rv & 32'h1, 32'h1);
      check(irq, 1'b1);
      wr(IDX_IRQ_CLR, 8'h01);
      repeat (2) @(posedge clk);
      check(irq, 1'b0);
      apb(1'b0, IDX_IRQ_STAT, 8'h00);
      check(rv & 32'h1, 32'h0);
      $display("test interrupt done");

      wr(IDX_CTRL, 8'h00);
      wr(IDX_CNT_HI, 8'h12);
      wr(IDX_CNT_LO, 8'hfe);
      wr(IDX_CTRL, 8'h04);
      repeat (4) @(posedge clk);
      apb(1'b0, IDX_CNT_LO, 8'h00);
      check(rv[7:0] < 8'h10, 1'b1);
      rd(IDX_CNT_HI, 32'h00000013);
      $display("test combined count done");

      summarize();
   end

endmodule : split_timer_tb

`default_nettype wire
